// ---- supervisor_defines.svh ----
/*
 Timing constants, widths and reset levels of the reset supervisor.
 Assumes a 100 MHz system clock and a 1 us internal timebase tick.
*/
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

`define CLK_PERIOD_NS    10
`define TICK_TIME_NS     1000
`define TICK_CYCLES      (`TICK_TIME_NS / `CLK_PERIOD_NS)

`define TIMEOUT_TIME_MS  800
`define TIMEOUT_TICKS    (`TIMEOUT_TIME_MS * 1000000 / `TICK_TIME_NS)

`define LOCKOUT_TIME_US  49
`define LOCKOUT_MAX_US   122
`define LOCKOUT_TICKS    (`LOCKOUT_TIME_US * 1000 / `TICK_TIME_NS)
`define LOCKOUT_MAX_TICKS (`LOCKOUT_MAX_US * 1000 / `TICK_TIME_NS)

`define DEBOUNCE_TIME_US 10
`define DEBOUNCE_CYCLES  (`DEBOUNCE_TIME_US * 1000 / `CLK_PERIOD_NS)

`define TICK_CNT_W       20
`define DIV_CNT_W        12
`define DB_CNT_W         12

`define MR_IDLE_LEVEL    1'b1
`define PIN_LOW_LEVEL    1'b0

`endif

// ---- supervisor_pkg.sv ----
/*
 Types of the reset supervisor: sequencer states and register images.
 Assumes supervisor_defines.svh is on the include path.
*/
`include "supervisor_defines.svh"

package supervisor_pkg;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_UV      = 4'b0010,
        ST_TIMEOUT = 4'b0100,
        ST_LOCKOUT = 4'b1000
    } sup_state_t;

    typedef struct packed {
        logic                   uv_s1;
        logic                   uv_s2;
        logic                   mr_s1;
        logic                   mr_s2;
        logic                   mr_db;
        logic [`DB_CNT_W-1:0]   db_cnt;
        sup_state_t             state;
        logic                   manual;
        logic [`TICK_CNT_W-1:0] tick_cnt;
        logic                   rst;
        logic                   drive_n;
        logic                   pin;
    } sup_regs_t;

    typedef struct packed {
        logic [`DIV_CNT_W-1:0]  cnt;
        logic                   tick;
    } div_regs_t;

endpackage

// ---- tick_if.sv ----
/*
 Carrier between the sequencer and its timebase divider.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface tick_if;
    logic restart;
    logic tick;

    modport src  (input restart, output tick);
    modport user (output restart, input tick);
endinterface

// ---- tick_timebase.sv ----
/*
 Free-running timebase: one-cycle tick every TICK_CYCLES clocks.
 Assumes restart comes from logic on the same clock; restart realigns
 the phase so a timed interval never starts mid-tick.
*/
`timescale 1ns/1ps
`include "supervisor_defines.svh"

module tick_timebase
    import supervisor_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    tick_if.src       tb
);

    localparam logic [`DIV_CNT_W-1:0] LAST =
        `DIV_CNT_W'(TICK_CYCLES - 1);

    if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << `DIV_CNT_W)) begin : g_chk
        $error("tick_timebase: TICK_CYCLES out of range");
    end

    div_regs_t q;
    div_regs_t d;

    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (tb.restart) begin
            d.cnt = '0;
        end else if (q.cnt == LAST) begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tb.tick = q.tick;

endmodule

// ---- supervisory_reset_pulse_gen.sv ----
/*
 Reset supervisor: undervoltage hold with time-out, debounced
 edge-triggered manual reset with a post-pulse lockout, and both an
 open-drain active-low and a push-pull active-high reset output.
 Assumes an analog comparator drives undervoltage_in and that the
 external pull-up on the open-drain pin makes the high level.
*/
// Functional notes
// - Undervoltage asserts reset; hold it at least 800 ms after recovery.
// - Manual reset pulse lasts between 800 ms and 2 s.
// - Manual input is debounced and acts only on a falling edge.
// - After a manual pulse, ignore the manual input at least 49 us.
// - Each accepted falling edge yields exactly one time-out pulse.
// - Active-low output is open-drain: pull low when asserted, else release.
// - Active-high output drives high when asserted, low otherwise.
// - Manual input idles high; unconnected never triggers reset.
// - Lockout after a manual pulse lasts no more than 122 us.
`timescale 1ns/1ps
`include "supervisor_defines.svh"

module supervisory_reset_pulse_gen
    import supervisor_pkg::*;
#(
    parameter int TICK_CYCLES     = `TICK_CYCLES,
    parameter int TIMEOUT_TICKS   = `TIMEOUT_TICKS,
    parameter int LOCKOUT_TICKS   = `LOCKOUT_TICKS,
    parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic undervoltage_in,
    input  wire logic manual_reset_n_in,
    input  wire logic reset_n_pin_in,
    output wire logic reset_n_out,
    output wire logic reset_n_drive_n_out,
    output wire logic reset_out
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (TIMEOUT_TICKS < 1 || TIMEOUT_TICKS > (1 << `TICK_CNT_W) ||
        LOCKOUT_TICKS < 1 || LOCKOUT_TICKS > (1 << `TICK_CNT_W) ||
        LOCKOUT_TICKS > `LOCKOUT_MAX_TICKS ||
        DEBOUNCE_CYCLES < 1 ||
        DEBOUNCE_CYCLES > (1 << `DB_CNT_W)) begin : g_chk
        $error("supervisor: timing parameter out of range");
    end

    localparam logic [`TICK_CNT_W-1:0] TO_LAST =
        `TICK_CNT_W'(TIMEOUT_TICKS - 1);
    localparam logic [`TICK_CNT_W-1:0] LO_LAST =
        `TICK_CNT_W'(LOCKOUT_TICKS - 1);
    localparam logic [`DB_CNT_W-1:0]   DB_LAST =
        `DB_CNT_W'(DEBOUNCE_CYCLES - 1);

    // Power-on behaves like a supply recovery: reset held one time-out
    localparam sup_regs_t INIT = '{
        uv_s1:    1'b0,
        uv_s2:    1'b0,
        mr_s1:    `MR_IDLE_LEVEL,
        mr_s2:    `MR_IDLE_LEVEL,
        mr_db:    `MR_IDLE_LEVEL,
        db_cnt:   '0,
        state:    ST_TIMEOUT,
        manual:   1'b0,
        tick_cnt: '0,
        rst:      1'b1,
        drive_n:  1'b0,
        pin:      `PIN_LOW_LEVEL
    };

    // ------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------
    tick_if tb ();

    tick_timebase #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timebase (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .tb         (tb.src)
    );

    sup_regs_t q;
    sup_regs_t d;
    logic      mr_fall;
    logic      restart;

    assign tb.restart = restart;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        d       = q;
        restart = 1'b0;
        mr_fall = 1'b0;
        d.uv_s1 = undervoltage_in;
        d.uv_s2 = q.uv_s1;
        d.mr_s1 = manual_reset_n_in;
        d.mr_s2 = q.mr_s1;

        // A level must stay put for the whole window; bounces restart it
        if (q.mr_s2 == q.mr_db) begin
            d.db_cnt = '0;
        end else if (q.db_cnt == DB_LAST) begin
            d.mr_db  = q.mr_s2;
            d.db_cnt = '0;
            mr_fall  = ~q.mr_s2;
        end else begin
            d.db_cnt = q.db_cnt + 1'b1;
        end

        unique case (q.state)
            ST_IDLE: begin
                // A held low level never gives a second edge
                if (mr_fall) begin
                    d.state    = ST_TIMEOUT;
                    d.manual   = 1'b1;
                    d.tick_cnt = '0;
                    restart    = 1'b1;
                end
            end
            ST_UV: begin
                if (!q.uv_s2) begin
                    d.state    = ST_TIMEOUT;
                    d.manual   = 1'b0;
                    d.tick_cnt = '0;
                    restart    = 1'b1;
                end
            end
            ST_TIMEOUT: begin
                if (tb.tick) begin
                    if (q.tick_cnt == TO_LAST) begin
                        d.tick_cnt = '0;
                        d.state    = q.manual ? ST_LOCKOUT : ST_IDLE;
                        restart    = q.manual;
                    end else begin
                        d.tick_cnt = q.tick_cnt + 1'b1;
                    end
                end
            end
            ST_LOCKOUT: begin
                // Edges seen here are dropped, not queued
                if (tb.tick) begin
                    if (q.tick_cnt == LO_LAST) begin
                        d.tick_cnt = '0;
                        d.state    = ST_IDLE;
                        d.manual   = 1'b0;
                    end else begin
                        d.tick_cnt = q.tick_cnt + 1'b1;
                    end
                end
            end
        endcase

        // Undervoltage overrides any manual phase
        if (q.uv_s2) begin
            d.state    = ST_UV;
            d.manual   = 1'b0;
            d.tick_cnt = '0;
        end

        d.rst     = (d.state == ST_UV) || (d.state == ST_TIMEOUT);
        d.drive_n = ~d.rst;
        d.pin     = `PIN_LOW_LEVEL;
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q <= INIT;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reset_n_out         = q.pin;
    assign reset_n_drive_n_out = q.drive_n;
    assign reset_out           = q.rst;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    localparam int TO_MIN = TIMEOUT_TICKS * TICK_CYCLES;
    localparam int TO_MAX = (TIMEOUT_TICKS + 1) * (TICK_CYCLES + 1) + 4;
    localparam int LO_MIN = LOCKOUT_TICKS * TICK_CYCLES;
    localparam int LO_MAX = LOCKOUT_TICKS * (TICK_CYCLES + 1) + 2;

    int unsigned rel_cnt;
    int unsigned lock_cnt;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in || q.uv_s2 || !q.rst) begin
            rel_cnt <= 0;
        end else begin
            rel_cnt <= rel_cnt + 1;
        end
        if (!reset_n_in || q.state == ST_TIMEOUT) begin
            lock_cnt <= 0;
        end else if (q.state == ST_LOCKOUT) begin
            lock_cnt <= lock_cnt + 1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_manual_start;
        q.state == ST_IDLE && mr_fall && !q.uv_s2;
    endsequence

    sequence s_lockout_done;
        q.state == ST_IDLE && $past(q.state) == ST_LOCKOUT;
    endsequence

    a_uv_forces_reset: assert property (
        q.uv_s2 |=> reset_out && !reset_n_drive_n_out)
        else $error("undervoltage did not assert reset");

    a_timeout_min: assert property (
        $fell(reset_out) |-> rel_cnt >= TO_MIN)
        else $error("reset released before time-out");

    a_timeout_max: assert property (
        reset_out |-> rel_cnt <= TO_MAX)
        else $error("reset held past maximum time-out");

    a_edge_pulse: assert property (
        s_manual_start |=> reset_out [*4])
        else $error("falling edge gave no reset pulse");

    a_level_no_trig: assert property (
        (q.state == ST_IDLE && !mr_fall && !q.uv_s2) |=> !reset_out)
        else $error("reset started without a falling edge");

    a_lockout_block: assert property (
        (q.state == ST_LOCKOUT && !q.uv_s2) |=> !reset_out)
        else $error("reset started during lockout");

    a_lockout_len: assert property (
        s_lockout_done |-> lock_cnt >= LO_MIN && lock_cnt <= LO_MAX)
        else $error("lockout length out of range");

    a_pulse_lockout: assert property (
        ($fell(reset_out) && q.manual) |-> q.state == ST_LOCKOUT)
        else $error("manual pulse not followed by lockout");

    a_drive_high: assert property (
        $rose(reset_out) |-> $past(q.uv_s2) || $past(mr_fall)
                             || $past(q.state) == ST_UV)
        else $error("reset rose without a cause");

    a_open_drain: assert property (
        (reset_n_drive_n_out == !reset_out) && !reset_n_out)
        else $error("open-drain drive does not match reset");

endmodule

// ---- reset_far_side_model.sv ----
/*
 Far side of the supervisor: pull-up on the open-drain reset pin, a
 processor reset input that counts pulses, and a manual switch.
 Assumes the bench moves the switch just after a rising clock edge.
*/
`timescale 1ns/1ps

module reset_far_side_model (
    input  wire logic       clk_in,
    input  wire logic       drive_n_in,
    input  wire logic       data_in,
    input  wire logic       press_in,
    output wire logic       pin_out,
    output wire logic       manual_reset_n_out,
    output wire logic [7:0] pulses_out
);
    // Declaration values give the counter a known start without a reset
    logic       pin_q = 1'b1;
    logic [7:0] cnt_q = 8'h00;

    assign pulses_out = cnt_q;

    // Released pin floats up through the external resistor
    assign pin_out = drive_n_in ? 1'b1 : data_in;
    // Switch shorts to ground; an open input idles high
    assign manual_reset_n_out = press_in ? 1'b0 : 1'b1;

    // The processor sees one reset per falling pin edge
    always @(posedge clk_in) begin
        if (pin_q && !pin_out)
            cnt_q <= cnt_q + 8'h01;
        pin_q <= pin_out;
    end
endmodule

// ---- tb_supervisory_reset_pulse_gen.sv ----
/*
 Self-checking bench of the reset supervisor with shortened counts.
 Assumes the far-side model resolves the pin and the manual switch.
*/
`timescale 1ns/1ps

module tb_supervisory_reset_pulse_gen;
    localparam int TCK   = 4;
    localparam int TMO   = 20;
    localparam int PULSE = TMO * TCK;
    // Upper bound scales 2 s against the 800 ms minimum
    localparam int PMAX  = PULSE * 5 / 2;
    localparam int DBC   = 8;

    logic       clk_in;
    logic       reset_n_in;
    logic       undervoltage_in;
    logic       press;
    wire logic  reset_n_out;
    wire logic  drive_n;
    wire logic  reset_out;
    wire logic  pin;
    wire logic  mr_n;
    wire logic [7:0] pulses;
    int         n_fail;
    int         compares;

    supervisory_reset_pulse_gen #(
        .TICK_CYCLES    (TCK),
        .TIMEOUT_TICKS  (TMO),
        .LOCKOUT_TICKS  (5),
        .DEBOUNCE_CYCLES(DBC)
    ) uut (
        .clk_in             (clk_in),
        .reset_n_in         (reset_n_in),
        .undervoltage_in    (undervoltage_in),
        .manual_reset_n_in  (mr_n),
        .reset_n_pin_in     (pin),
        .reset_n_out        (reset_n_out),
        .reset_n_drive_n_out(drive_n),
        .reset_out          (reset_out)
    );

    reset_far_side_model far (
        .clk_in            (clk_in),
        .drive_n_in        (drive_n),
        .data_in           (reset_n_out),
        .press_in          (press),
        .pin_out           (pin),
        .manual_reset_n_out(mr_n),
        .pulses_out        (pulses)
    );

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic fail(input string msg);
        n_fail++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task automatic chk_bit(input logic got, input logic exp,
                           input string msg);
        compares++;
        if (got !== exp)
            fail(msg);
    endtask

    task automatic chk_range(input int v, input int lo, input int hi,
                             input string msg);
        compares++;
        if (v < lo || v > hi)
            fail(msg);
    endtask

    task automatic wait_rst(input logic v, input int lim, output int n);
        n = 0;
        while (reset_out !== v && n < lim) begin
            @(negedge clk_in);
            n++;
        end
        if (reset_out !== v) begin
            fail("reset output wait ran out");
            report_and_stop();
        end
    endtask

    task automatic hold_lvl(input logic v, input int cyc, input string msg);
        repeat (cyc) begin
            @(negedge clk_in);
            chk_bit(reset_out, v, msg);
            chk_bit(pin, !v, "pin level differs");
        end
    endtask

    task automatic set_press(input logic v);
        @(posedge clk_in);
        press <= v;
        @(negedge clk_in);
    endtask

    task automatic report_and_stop;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power_on;
        int n;
        chk_bit(reset_out, 1'b1, "no reset at power-on");
        chk_bit(pin, 1'b0, "pin not pulled low");
        chk_bit(reset_n_out, 1'b0, "pin data not low");
        wait_rst(1'b0, PMAX + 8, n);
        chk_range(n, PULSE, PMAX, "power-on time-out length");
        $display("test power_on done");
    endtask

    task automatic t_idle_and_glitch;
        hold_lvl(1'b0, 60, "open input gave reset");
        set_press(1'b1);
        repeat (3) @(negedge clk_in);
        set_press(1'b0);
        hold_lvl(1'b0, 40, "glitch gave reset");
        $display("test idle_and_glitch done");
    endtask

    task automatic t_manual_lockout;
        int n;
        logic [7:0] p0;
        p0 = pulses;
        set_press(1'b1);
        wait_rst(1'b1, DBC + 6, n);
        hold_lvl(1'b1, 40, "pulse cut short");
        set_press(1'b0);
        wait_rst(1'b0, PMAX, n);
        chk_range(n + 41, PULSE, PMAX, "manual pulse length");
        // Edge lands inside the lockout, then stays low past it
        set_press(1'b1);
        hold_lvl(1'b0, 30, "edge in lockout accepted");
        chk_bit(pulses === p0 + 8'h01, 1'b1, "pulse count");
        set_press(1'b0);
        repeat (14) @(negedge clk_in);
        set_press(1'b1);
        wait_rst(1'b1, DBC + 6, n);
        wait_rst(1'b0, PMAX, n);
        chk_range(n, PULSE, PMAX, "second pulse length");
        set_press(1'b0);
        chk_bit(pulses === p0 + 8'h02, 1'b1, "second pulse");
        $display("test manual_lockout done");
    endtask

    task automatic t_undervoltage;
        int n;
        @(posedge clk_in);
        undervoltage_in <= 1'b1;
        wait_rst(1'b1, 4, n);
        hold_lvl(1'b1, 40, "reset dropped in dip");
        @(posedge clk_in);
        undervoltage_in <= 1'b0;
        wait_rst(1'b0, PMAX, n);
        chk_range(n, PULSE, PMAX, "recovery time-out length");
        $display("test undervoltage done");
    endtask

    // ------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    initial begin
        n_fail = 0;
        compares = 0;
        reset_n_in = 1'b0;
        undervoltage_in = 1'b0;
        press = 1'b0;
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(negedge clk_in);
        t_power_on();
        t_idle_and_glitch();
        t_manual_lockout();
        t_undervoltage();
        report_and_stop();
    end
endmodule
